// File: src/ipr_bank.v
// Purpose: priority registers three to eight, exporting 22 source levels
// Assumes: software port with read data one cycle after the read strobe
// Notes: level 000 disables a source; levels feed arbitration outside
//
// Behaviour
// - fields are 3 bits, 7 highest, 1 lowest
// - field 000 disables the source's request
// - unimplemented bits read zero, writes ignored
// - each field resets to binary 100
// - fields read back last written value
// - register three: dma1, adc1, uart1 tx
// - register four: pin change, i2c1 master, slave
// - register five: capture 8, 7, adc2, ext1
// - register six: timer4, compare 4, 3, dma2
// - register seven: uart2 tx, rx, ext2, timer5
// - register eight: can1 event, rx, spi2 event, error
// - bits 15, 11, 7, 3 are spacers
//
// The placing of the registers and the strobed register port were left to the implementer.
`default_nettype none
`include "ipr_map.vh"

module ipr_bank
(
  // clock and reset
  input wire mclk,
  input wire rst,
  // register port
  input wire [`IPR_ADDR_W-1:0] addr,
  input wire [`IPR_DATA_W-1:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [`IPR_DATA_W-1:0] rdata,
  // levels to arbitration
  output reg [2:0] dma_ch1_done_level,
  output reg [2:0] adc_one_done_level,
  output reg [2:0] serial_one_tx_level,
  output reg [2:0] pin_change_level,
  output reg [2:0] i2c_one_master_level,
  output reg [2:0] i2c_one_slave_level,
  output reg [2:0] capture_eight_level,
  output reg [2:0] capture_seven_level,
  output reg [2:0] adc_two_done_level,
  output reg [2:0] ext_irq_one_level,
  output reg [2:0] timer_four_level,
  output reg [2:0] compare_four_level,
  output reg [2:0] compare_three_level,
  output reg [2:0] dma_ch2_done_level,
  output reg [2:0] serial_two_tx_level,
  output reg [2:0] serial_two_rx_level,
  output reg [2:0] ext_irq_two_level,
  output reg [2:0] timer_five_level,
  output reg [2:0] can_one_event_level,
  output reg [2:0] can_one_rx_level,
  output reg [2:0] spi_two_event_level,
  output reg [2:0] spi_two_error_level,
  // per-source request enable, low when level is 000
  output reg [21:0] source_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  wire [`IPR_DATA_W-1:0] word [0:`IPR_NUM_REGS-1];
  wire [`IPR_NUM_REGS-1:0] wr_sel;

  genvar gi;
  generate
    for (gi = 0; gi < `IPR_NUM_REGS; gi = gi + 1)
    begin : g_reg
      // registers three and four have one field missing
      localparam [15:0] MASK = (gi == 0) ? `IPR_MASK_REG3 :
        (gi == 1) ? `IPR_MASK_REG4 : `IPR_MASK_FULL;
      localparam [15:0] RST = (gi == 0) ? `IPR_RESET_REG3 :
        (gi == 1) ? `IPR_RESET_REG4 : `IPR_RESET_FULL;
      // word index of this register on the software port
      localparam [`IPR_ADDR_W-1:0] OFS = (gi == 0) ? `IPR_OFS_REG3 :
        (gi == 1) ? `IPR_OFS_REG4 :
        (gi == 2) ? `IPR_OFS_REG5 :
        (gi == 3) ? `IPR_OFS_REG6 :
        (gi == 4) ? `IPR_OFS_REG7 : `IPR_OFS_REG8;
      assign wr_sel[gi] = wr_stb && (addr == OFS);
      ipr_word
      #(
        .IMPL_MASK(MASK),
        .RESET_VAL(RST)
      )
      u_word
      (
        .mclk(mclk),
        .rst(rst),
        .wr_en(wr_sel[gi]),
        .wr_data(wdata),
        .value_reg(word[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read port, unmapped addresses read zero
  reg [`IPR_DATA_W-1:0] rd_word;

  always @*
  begin
    case (addr)
      `IPR_OFS_REG3: rd_word = word[0];
      `IPR_OFS_REG4: rd_word = word[1];
      `IPR_OFS_REG5: rd_word = word[2];
      `IPR_OFS_REG6: rd_word = word[3];
      `IPR_OFS_REG7: rd_word = word[4];
      `IPR_OFS_REG8: rd_word = word[5];
      default: rd_word = 16'h0000;
    endcase
  end

  // data stands one cycle only, so a stale word never lingers
  always @(posedge mclk)
  begin
    if (rst)
      rdata <= 16'h0000;
    else if (rd_stb)
      rdata <= rd_word;
    else
      rdata <= 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next register words: the level flops load on the same edge as
  // the register, so an exported level never lags its readback
  wire [`IPR_DATA_W-1:0] word0_next;
  wire [`IPR_DATA_W-1:0] word1_next;
  wire [`IPR_DATA_W-1:0] word2_next;
  wire [`IPR_DATA_W-1:0] word3_next;
  wire [`IPR_DATA_W-1:0] word4_next;
  wire [`IPR_DATA_W-1:0] word5_next;

  assign word0_next = wr_sel[0] ? (wdata & `IPR_MASK_REG3) : word[0];
  assign word1_next = wr_sel[1] ? (wdata & `IPR_MASK_REG4) : word[1];
  assign word2_next = wr_sel[2] ? (wdata & `IPR_MASK_FULL) : word[2];
  assign word3_next = wr_sel[3] ? (wdata & `IPR_MASK_FULL) : word[3];
  assign word4_next = wr_sel[4] ? (wdata & `IPR_MASK_FULL) : word[4];
  assign word5_next = wr_sel[5] ? (wdata & `IPR_MASK_FULL) : word[5];

  // field slices per source; spacer bits never reach a level
  // register three
  wire [2:0] dma_ch1_done_level_next =
    word0_next[`IPR_FLD2_LSB +: `IPR_FIELD_W];
  wire [2:0] adc_one_done_level_next =
    word0_next[`IPR_FLD1_LSB +: `IPR_FIELD_W];
  wire [2:0] serial_one_tx_level_next =
    word0_next[`IPR_FLD0_LSB +: `IPR_FIELD_W];

  // register four
  wire [2:0] pin_change_level_next =
    word1_next[`IPR_FLD3_LSB +: `IPR_FIELD_W];
  wire [2:0] i2c_one_master_level_next =
    word1_next[`IPR_FLD1_LSB +: `IPR_FIELD_W];
  wire [2:0] i2c_one_slave_level_next =
    word1_next[`IPR_FLD0_LSB +: `IPR_FIELD_W];

  // register five
  wire [2:0] capture_eight_level_next =
    word2_next[`IPR_FLD3_LSB +: `IPR_FIELD_W];
  wire [2:0] capture_seven_level_next =
    word2_next[`IPR_FLD2_LSB +: `IPR_FIELD_W];
  wire [2:0] adc_two_done_level_next =
    word2_next[`IPR_FLD1_LSB +: `IPR_FIELD_W];
  wire [2:0] ext_irq_one_level_next =
    word2_next[`IPR_FLD0_LSB +: `IPR_FIELD_W];

  // register six
  wire [2:0] timer_four_level_next =
    word3_next[`IPR_FLD3_LSB +: `IPR_FIELD_W];
  wire [2:0] compare_four_level_next =
    word3_next[`IPR_FLD2_LSB +: `IPR_FIELD_W];
  wire [2:0] compare_three_level_next =
    word3_next[`IPR_FLD1_LSB +: `IPR_FIELD_W];
  wire [2:0] dma_ch2_done_level_next =
    word3_next[`IPR_FLD0_LSB +: `IPR_FIELD_W];

  // register seven
  wire [2:0] serial_two_tx_level_next =
    word4_next[`IPR_FLD3_LSB +: `IPR_FIELD_W];
  wire [2:0] serial_two_rx_level_next =
    word4_next[`IPR_FLD2_LSB +: `IPR_FIELD_W];
  wire [2:0] ext_irq_two_level_next =
    word4_next[`IPR_FLD1_LSB +: `IPR_FIELD_W];
  wire [2:0] timer_five_level_next =
    word4_next[`IPR_FLD0_LSB +: `IPR_FIELD_W];

  // register eight
  wire [2:0] can_one_event_level_next =
    word5_next[`IPR_FLD3_LSB +: `IPR_FIELD_W];
  wire [2:0] can_one_rx_level_next =
    word5_next[`IPR_FLD2_LSB +: `IPR_FIELD_W];
  wire [2:0] spi_two_event_level_next =
    word5_next[`IPR_FLD1_LSB +: `IPR_FIELD_W];
  wire [2:0] spi_two_error_level_next =
    word5_next[`IPR_FLD0_LSB +: `IPR_FIELD_W];

  // flattened next levels, source order matches source_enable bits
  wire [65:0] lv_next = {
    dma_ch1_done_level_next,
    adc_one_done_level_next,
    serial_one_tx_level_next,
    pin_change_level_next,
    i2c_one_master_level_next,
    i2c_one_slave_level_next,
    capture_eight_level_next,
    capture_seven_level_next,
    adc_two_done_level_next,
    ext_irq_one_level_next,
    timer_four_level_next,
    compare_four_level_next,
    compare_three_level_next,
    dma_ch2_done_level_next,
    serial_two_tx_level_next,
    serial_two_rx_level_next,
    ext_irq_two_level_next,
    timer_five_level_next,
    can_one_event_level_next,
    can_one_rx_level_next,
    spi_two_event_level_next,
    spi_two_error_level_next};

  wire [21:0] en_next;
  generate
    for (gi = 0; gi < 22; gi = gi + 1)
    begin : g_en
      assign en_next[gi] =
        (lv_next[gi*3 +: 3] != `IPR_LEVEL_OFF);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // level flops; reset puts every source at the middle level
  // registers three and four
  always @(posedge mclk)
  begin
    if (rst)
    begin
      dma_ch1_done_level <= `IPR_FIELD_RESET;
      adc_one_done_level <= `IPR_FIELD_RESET;
      serial_one_tx_level <= `IPR_FIELD_RESET;
      pin_change_level <= `IPR_FIELD_RESET;
      i2c_one_master_level <= `IPR_FIELD_RESET;
      i2c_one_slave_level <= `IPR_FIELD_RESET;
    end
    else
    begin
      dma_ch1_done_level <= dma_ch1_done_level_next;
      adc_one_done_level <= adc_one_done_level_next;
      serial_one_tx_level <= serial_one_tx_level_next;
      pin_change_level <= pin_change_level_next;
      i2c_one_master_level <= i2c_one_master_level_next;
      i2c_one_slave_level <= i2c_one_slave_level_next;
    end
  end

  // registers five and six
  always @(posedge mclk)
  begin
    if (rst)
    begin
      capture_eight_level <= `IPR_FIELD_RESET;
      capture_seven_level <= `IPR_FIELD_RESET;
      adc_two_done_level <= `IPR_FIELD_RESET;
      ext_irq_one_level <= `IPR_FIELD_RESET;
      timer_four_level <= `IPR_FIELD_RESET;
      compare_four_level <= `IPR_FIELD_RESET;
      compare_three_level <= `IPR_FIELD_RESET;
      dma_ch2_done_level <= `IPR_FIELD_RESET;
    end
    else
    begin
      capture_eight_level <= capture_eight_level_next;
      capture_seven_level <= capture_seven_level_next;
      adc_two_done_level <= adc_two_done_level_next;
      ext_irq_one_level <= ext_irq_one_level_next;
      timer_four_level <= timer_four_level_next;
      compare_four_level <= compare_four_level_next;
      compare_three_level <= compare_three_level_next;
      dma_ch2_done_level <= dma_ch2_done_level_next;
    end
  end

  // registers seven and eight
  always @(posedge mclk)
  begin
    if (rst)
    begin
      serial_two_tx_level <= `IPR_FIELD_RESET;
      serial_two_rx_level <= `IPR_FIELD_RESET;
      ext_irq_two_level <= `IPR_FIELD_RESET;
      timer_five_level <= `IPR_FIELD_RESET;
      can_one_event_level <= `IPR_FIELD_RESET;
      can_one_rx_level <= `IPR_FIELD_RESET;
      spi_two_event_level <= `IPR_FIELD_RESET;
      spi_two_error_level <= `IPR_FIELD_RESET;
    end
    else
    begin
      serial_two_tx_level <= serial_two_tx_level_next;
      serial_two_rx_level <= serial_two_rx_level_next;
      ext_irq_two_level <= ext_irq_two_level_next;
      timer_five_level <= timer_five_level_next;
      can_one_event_level <= can_one_event_level_next;
      can_one_rx_level <= can_one_rx_level_next;
      spi_two_event_level <= spi_two_event_level_next;
      spi_two_error_level <= spi_two_error_level_next;
    end
  end

  // request enables; low while a source's level is 000
  always @(posedge mclk)
  begin
    if (rst)
      source_enable <= `IPR_ENABLE_RESET;
    else
      source_enable <= en_next;
  end

endmodule // ipr_bank

`default_nettype wire

// File: src/ipr_map.vh
// Purpose: constants for the priority register bank, registers three to eight
// Assumes: plain register port, 16-bit data, index addressing
// Notes: offsets are word indices of this bank
`ifndef IPR_MAP_VH
`define IPR_MAP_VH

`define IPR_ADDR_W 3
`define IPR_DATA_W 16
`define IPR_NUM_REGS 6
`define IPR_OFS_REG3 3'h0
`define IPR_OFS_REG4 3'h1
`define IPR_OFS_REG5 3'h2
`define IPR_OFS_REG6 3'h3
`define IPR_OFS_REG7 3'h4
`define IPR_OFS_REG8 3'h5
`define IPR_FIELD_W 3
`define IPR_FIELD_RESET 3'h4
`define IPR_LEVEL_OFF 3'h0
`define IPR_FLD3_LSB 12
`define IPR_FLD2_LSB 8
`define IPR_FLD1_LSB 4
`define IPR_FLD0_LSB 0
`define IPR_MASK_REG3 16'h0777
`define IPR_MASK_REG4 16'h7077
`define IPR_MASK_FULL 16'h7777
`define IPR_RESET_REG3 16'h0444
`define IPR_RESET_REG4 16'h4044
`define IPR_RESET_FULL 16'h4444
`define IPR_ENABLE_RESET 22'h3f_ffff

`endif

// File: src/ipr_word.v
// Purpose: one 16-bit priority register with an implemented-bit mask
// Assumes: synchronous active-high reset on mclk
// Notes: unimplemented bits are never stored, so they always read zero
`default_nettype none

module ipr_word
#(
  parameter [15:0] IMPL_MASK = 16'h7777,
  parameter [15:0] RESET_VAL = 16'h4444
)
(
  // clock and reset
  input wire mclk,
  input wire rst,
  // write side
  input wire wr_en,
  input wire [15:0] wr_data,
  // stored value
  output reg [15:0] value_reg
);

  always @(posedge mclk)
  begin
    if (rst)
      value_reg <= RESET_VAL & IMPL_MASK;
    else if (wr_en)
      value_reg <= wr_data & IMPL_MASK;
  end

endmodule // ipr_word

`default_nettype wire

// File: testbench/ipr_chk_assertions.sv
// Purpose: port checks for the priority register bank
// Assumes: one clock, sync active-high reset
// Notes: watches a subset of the level outputs
`default_nettype none
module ipr_chk
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [15:0] rdata,
  // levels
  input wire logic [2:0] dma_ch1_done_level,
  input wire logic [2:0] pin_change_level,
  input wire logic [2:0] spi_two_error_level,
  input wire logic [21:0] source_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff rst;
  AST_RST_LEVEL: assert property ($fell(rst) |->
    source_enable == 22'h3f_ffff && dma_ch1_done_level == 3'h4) else $error("rst");
  AST_ENABLE_OFF: assert property (
    source_enable[0] == (spi_two_error_level != 3'h0)) else $error("enable");
  AST_REG3_FIELD: assert property (wr_stb && addr == 3'h0 |=>
    dma_ch1_done_level == $past(wdata[10:8])) else $error("reg3");
  AST_REG4_FIELD: assert property (wr_stb && addr == 3'h1 |=>
    pin_change_level == $past(wdata[14:12])) else $error("reg4");
  AST_REG8_FIELD: assert property (wr_stb && addr == 3'h5 |=>
    spi_two_error_level == $past(wdata[2:0])) else $error("reg8");
  AST_LEVEL_HOLD: assert property (!(wr_stb && addr == 3'h5) |=>
    $stable(spi_two_error_level)) else $error("hold");
  AST_RD_ONE_CYCLE: assert property (!rd_stb |=>
    rdata == 16'h0000) else $error("rdata");
  AST_RD_SPACER: assert property (rd_stb && addr == 3'h0 |=>
    (rdata & 16'hf888) == 16'h0000) else $error("spacer");
endmodule // ipr_chk
////////////////////////////////////////////////////////////////////////////
bind ipr_bank ipr_chk u_chk (.mclk(mclk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .dma_ch1_done_level(dma_ch1_done_level), .pin_change_level(pin_change_level),
  .spi_two_error_level(spi_two_error_level), .source_enable(source_enable));
`default_nettype wire

// File: testbench/ipr_tb.sv
// Purpose: corner and random tests of the priority bank
// Assumes: read data one cycle after the read strobe
// Notes: all levels compared as one flat vector
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, wr_stb, rd_stb;
  logic [2:0] addr;
  logic [15:0] wdata, m [6];
  wire logic [15:0] rdata;
  wire logic [65:0] l;
  wire logic [21:0] en;
  int seed = 32'h1400_c320, errors = 0, compares = 0, i;
  ipr_bank i_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .source_enable(en),
    .dma_ch1_done_level(l[65:63]), .adc_one_done_level(l[62:60]),
    .serial_one_tx_level(l[59:57]), .pin_change_level(l[56:54]),
    .i2c_one_master_level(l[53:51]), .i2c_one_slave_level(l[50:48]),
    .capture_eight_level(l[47:45]), .capture_seven_level(l[44:42]),
    .adc_two_done_level(l[41:39]), .ext_irq_one_level(l[38:36]),
    .timer_four_level(l[35:33]), .compare_four_level(l[32:30]),
    .compare_three_level(l[29:27]), .dma_ch2_done_level(l[26:24]),
    .serial_two_tx_level(l[23:21]), .serial_two_rx_level(l[20:18]),
    .ext_irq_two_level(l[17:15]), .timer_five_level(l[14:12]),
    .can_one_event_level(l[11:9]), .can_one_rx_level(l[8:6]),
    .spi_two_event_level(l[5:3]), .spi_two_error_level(l[2:0]));
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  function automatic logic [15:0] msk(input logic [2:0] a);
    return a == 0 ? 16'h0777 : a == 1 ? 16'h7077 : a < 6 ? 16'h7777 : 16'h0000;
  endfunction
  // levels in port order, then one enable per level
  function automatic logic [87:0] lv_exp();
    logic [87:0] v = '0;
    logic [15:0] k;
    for (int r = 0; r < 6; r++)
    begin
      k = msk(r[2:0]);
      for (int f = 12; f >= 0; f -= 4)
        if (k[f]) v[87:22] = {v[84:22], m[r][f+:3]};
    end
    for (int s = 0; s < 22; s++) v[s] = v[22+3*s+:3] != 3'h0;
    return v;
  endfunction
  task automatic chk(input logic [87:0] s, e);
    compares++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic op(input logic w, input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr_stb <= w;
    rd_stb <= !w;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr_stb <= 0;
    rd_stb <= 0;
    if (w && a < 6) m[a] = d & msk(a);
    #1;
    if (!w) chk(rdata, a < 6 ? m[a] : 16'h0000);
    chk({l, en}, lv_exp());
  endtask
  task automatic do_reset();
    rst <= 1;
    repeat (5) @(posedge mclk);
    rst <= 0;
    for (int r = 0; r < 6; r++) m[r] = msk(r[2:0]) & 16'h4444;
    for (int a = 0; a < 8; a++) op(0, a[2:0], 16'h0000);
    $display("test reset done");
  endtask
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    rst = 1;
    wr_stb = 0;
    rd_stb = 0;
    addr = 0;
    wdata = 0;
    do_reset();
    // all ones hits every spacer, then lowest level, then disabled
    for (i = 0; i < 24; i++)
    begin
      op(1, i[2:0], i < 8 ? 16'hffff : i < 16 ? 16'h1111 : 16'h0000);
      op(0, i[2:0], 16'h0000);
    end
    $display("test corner done");
    repeat (200) op(1'($random(seed)), 3'($random(seed)), 16'($random(seed)));
    $display("test random done");
    do_reset();
    report_and_stop();
  end
  // about 500 cycles expected, cut at 3000
  initial
  begin
    #300000;
    errors++;
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
